// ---- core/peak_hold_pkg.sv ----
// Package with constants and types of the peak-hold sampler
`default_nettype none
package peak_hold_pkg;
    localparam int VALUE_W = 16;
    localparam logic [VALUE_W-1:0] VALUE_RESET = 16'h0000;
    localparam int ADDR_W = 4;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SELF_LEVEL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_HIGH_THR = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_LOW_THR = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_HELD = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_RUN_MAX = 4'h8;
    // Control field positions
    localparam int CTRL_SELF_BIT = 0;
    localparam int CTRL_CONT_BIT = 1;
    localparam int CTRL_RESET_BIT = 2;
    // Reset values
    localparam logic [VALUE_W-1:0] SELF_LEVEL_RESET = 16'h0100;
    localparam logic [VALUE_W-1:0] HIGH_THR_RESET = 16'hc000;
    localparam logic [VALUE_W-1:0] LOW_THR_RESET = 16'h4000;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // Interrupt bit positions
    localparam int IRQ_PUBLISH = 0;
    localparam int IRQ_START = 1;
    localparam int IRQ_ERR_CLR = 2;
    localparam int IRQ_FIRST = 3;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_IDLE = 2'b01,
        ST_SAMPLE = 2'b10
    } phase_e;

    typedef struct packed {
        logic high;
        logic go;
        logic low;
    } judge_s;
endpackage : peak_hold_pkg
`default_nettype wire

// ---- core/peak_hold_sampler.sv ----
// Peak-hold sampler with timing input, self-timing, judgement and register port
`default_nettype none
module peak_hold_sampler #(
    parameter int VALUE_W = peak_hold_pkg::VALUE_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [VALUE_W-1:0] live_value_i,
    input wire logic timing_i,
    input wire logic ext_reset_i,
    input wire logic set_button_i,
    input wire logic error_i,
    input wire logic [peak_hold_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [VALUE_W-1:0] held_value_o,
    output logic judge_high_o,
    output logic judge_go_o,
    output logic judge_low_o,
    output logic standby_o,
    output logic error_o,
    output logic irq_o
);
    // Width check at elaboration: thresholds and registers share the package width
    if (VALUE_W != peak_hold_pkg::VALUE_W) begin : g_bad_width
        $error("VALUE_W must match the package width");
    end

    typedef logic [VALUE_W-1:0] value_t;
    // Cleared maximum, declared ahead of every use
    localparam value_t VALUE_RESET_W = value_t'(peak_hold_pkg::VALUE_RESET);

    // Three-way judgement of a value against the thresholds
    function automatic peak_hold_pkg::judge_s judge(input value_t v, input value_t hi,
                                                   input value_t lo);
        peak_hold_pkg::judge_s j;
        j.high = (v > hi);
        j.low = (v < lo) && !(v > hi);
        j.go = !j.high && !j.low;
        return j;
    endfunction : judge

    // Registers and state
    logic [2:0] ctrl_r;
    value_t self_level_r, high_thr_r, low_thr_r;
    logic [3:0] irq_stat_r, irq_mask_r;
    value_t run_max_r, run_max_nxt;
    value_t held_r, held_nxt;
    peak_hold_pkg::judge_s judge_r, judge_nxt;
    peak_hold_pkg::phase_e phase_r, phase_nxt;
    logic frozen_r, frozen_nxt;
    logic error_r;
    logic standby_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic tim_s1_r, tim_s2_r, tim_s3_r;
    logic erst_s1_r, erst_s2_r, btn_s1_r, btn_s2_r, err_s1_r, err_s2_r;
    value_t live_s1_r, live_s2_r;
    logic above_r;

    // Decoded mode bits
    wire self_mode = ctrl_r[peak_hold_pkg::CTRL_SELF_BIT];
    wire cont_mode = ctrl_r[peak_hold_pkg::CTRL_CONT_BIT];
    wire soft_reset = reg_wr_i && reg_addr_i == peak_hold_pkg::OFS_CTRL
                      && reg_wdata_i[peak_hold_pkg::CTRL_RESET_BIT];

    // Timing edges and self-timing crossings
    wire tim_rise = tim_s2_r && !tim_s3_r;
    wire tim_fall = !tim_s2_r && tim_s3_r;
    wire above = live_s2_r > self_level_r;
    wire self_rise = above && !above_r;
    wire self_fall = !above && above_r;
    wire err_clear = error_r && (erst_s2_r || btn_s2_r);
    wire value_t max_up = (live_s2_r > run_max_r) ? live_s2_r : run_max_r;
    wire peak_hold_pkg::judge_s judge_max = judge(max_up, high_thr_r, low_thr_r);
    wire peak_hold_pkg::judge_s judge_off = '0;

    // Mode map of the tracking logic below:
    //   external timing, end update:   track while low, publish on rise
    //   external timing, continuous:   follow while low, freeze on rise, clear on fall
    //   self-timing, end update:       capture while above level, publish on fall
    //   self-timing, continuous:       restart on rise, follow while above level
    // Timing edges arrive two edges after the pin moves, so a pulse
    // shorter than one clock may be lost; the controller must hold levels.
    // Standby overrides every judgement until the first published value.

    // Peak tracking, display and judgement next state
    always_comb begin
        run_max_nxt = run_max_r;
        held_nxt = held_r;
        judge_nxt = judge_r;
        phase_nxt = phase_r;
        frozen_nxt = frozen_r;
        if (!self_mode) begin
            if (!cont_mode) begin
                if (tim_rise) begin
                    held_nxt = run_max_r;
                    judge_nxt = judge(run_max_r, high_thr_r, low_thr_r);
                    run_max_nxt = VALUE_RESET_W;
                    phase_nxt = peak_hold_pkg::ST_IDLE;
                end else if (!tim_s2_r) begin
                    run_max_nxt = max_up;
                end
            end else begin
                if (tim_rise) begin
                    frozen_nxt = 1'b1;
                    phase_nxt = peak_hold_pkg::ST_IDLE;
                end else if (tim_fall) begin
                    frozen_nxt = 1'b0;
                    run_max_nxt = VALUE_RESET_W;
                end else if (!tim_s2_r && !frozen_r) begin
                    run_max_nxt = max_up;
                    held_nxt = max_up;
                    judge_nxt = judge_max;
                    phase_nxt = peak_hold_pkg::ST_IDLE;
                end
            end
        end else begin
            if (self_rise) begin
                run_max_nxt = live_s2_r;
                if (cont_mode) begin
                    held_nxt = live_s2_r;
                    judge_nxt = judge(live_s2_r, high_thr_r, low_thr_r);
                end else begin
                    judge_nxt = judge_off;
                end
                if (phase_r != peak_hold_pkg::ST_STANDBY || cont_mode) begin
                    phase_nxt = peak_hold_pkg::ST_SAMPLE;
                end
            end else if (above) begin
                run_max_nxt = max_up;
                if (cont_mode) begin
                    held_nxt = max_up;
                    judge_nxt = judge_max;
                end
            end else if (self_fall) begin
                held_nxt = run_max_r;
                judge_nxt = judge(run_max_r, high_thr_r, low_thr_r);
                phase_nxt = peak_hold_pkg::ST_IDLE;
            end
            // Otherwise held value and judgement stand unchanged
        end
        if (phase_nxt == peak_hold_pkg::ST_STANDBY) begin
            judge_nxt = judge_off;
        end
    end

    // Interrupt events; first held value marks the end of standby
    wire first_held = phase_r == peak_hold_pkg::ST_STANDBY
                      && phase_nxt != peak_hold_pkg::ST_STANDBY;
    wire start_evt = self_mode ? self_rise : tim_fall;
    wire pub_evt = self_mode ? self_fall : tim_rise;
    wire [3:0] irq_set = {first_held, err_clear, start_evt, pub_evt};
    wire irq_clr_wr = reg_wr_i && reg_addr_i == peak_hold_pkg::OFS_IRQ_STAT;

    // Read data selection
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            peak_hold_pkg::OFS_CTRL: rd_mux = {29'h0, ctrl_r};
            peak_hold_pkg::OFS_SELF_LEVEL: rd_mux = 32'(self_level_r);
            peak_hold_pkg::OFS_HIGH_THR: rd_mux = 32'(high_thr_r);
            peak_hold_pkg::OFS_LOW_THR: rd_mux = 32'(low_thr_r);
            peak_hold_pkg::OFS_STATUS: rd_mux = {25'h0, error_r, frozen_r, phase_r,
                                                 judge_r};
            peak_hold_pkg::OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
            peak_hold_pkg::OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
            peak_hold_pkg::OFS_HELD: rd_mux = 32'(held_r);
            peak_hold_pkg::OFS_RUN_MAX: rd_mux = 32'(run_max_r);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Input synchronisers
    // The timing, external reset, button, error and live value pins pass two flops; only the timing input has a third
    // stage, used purely for edge detection against the second.
    // The live value bus is sampled as a word: it must be stable over
    // the synchroniser span, as a slowly moving sensor reading is.
    // The self-timing crossing is judged on the synchronised word so
    // that the level comparison never sees a half-updated value.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            {tim_s1_r, tim_s2_r, tim_s3_r} <= 3'h0;
            {erst_s1_r, erst_s2_r, btn_s1_r, btn_s2_r, err_s1_r, err_s2_r} <= 6'h00;
            live_s1_r <= VALUE_RESET_W;
            live_s2_r <= VALUE_RESET_W;
            above_r <= 1'b0;
        end else if (clk_en_i) begin
            tim_s1_r <= timing_i;
            tim_s2_r <= tim_s1_r;
            tim_s3_r <= tim_s2_r;
            erst_s1_r <= ext_reset_i;
            erst_s2_r <= erst_s1_r;
            btn_s1_r <= set_button_i;
            btn_s2_r <= btn_s1_r;
            err_s1_r <= error_i;
            err_s2_r <= err_s1_r;
            live_s1_r <= live_value_i;
            live_s2_r <= live_s1_r;
            above_r <= above;
        end
    end

    // Measurement state
    // Error clear and restart both return to standby with a blank display;
    // the standby flag is its own flop so the pin comes straight from it.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || (clk_en_i && (err_clear || soft_reset))) begin
            run_max_r <= VALUE_RESET_W;
            held_r <= VALUE_RESET_W;
            judge_r <= '0;
            phase_r <= peak_hold_pkg::ST_STANDBY;
            frozen_r <= 1'b0;
            standby_r <= 1'b1;
        end else if (clk_en_i) begin
            run_max_r <= run_max_nxt;
            held_r <= held_nxt;
            judge_r <= judge_nxt;
            phase_r <= phase_nxt;
            frozen_r <= frozen_nxt;
            standby_r <= (phase_nxt == peak_hold_pkg::ST_STANDBY);
        end
    end

    // Error latch: set by error input, cleared by external reset or button
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            error_r <= 1'b0;
        end else if (clk_en_i) begin
            if (err_s2_r) begin
                error_r <= 1'b1;
            end else if (err_clear) begin
                error_r <= 1'b0;
            end
        end
    end

    // Configuration registers
    // Restart bit of the control word is a strobe and is never stored.
    // Changing mode mid-period does not restart tracking by itself.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl_r <= peak_hold_pkg::CTRL_RESET;
            self_level_r <= value_t'(peak_hold_pkg::SELF_LEVEL_RESET);
            high_thr_r <= value_t'(peak_hold_pkg::HIGH_THR_RESET);
            low_thr_r <= value_t'(peak_hold_pkg::LOW_THR_RESET);
            irq_mask_r <= peak_hold_pkg::IRQ_MASK_RESET;
        end else if (clk_en_i && reg_wr_i) begin
            case (reg_addr_i)
                peak_hold_pkg::OFS_CTRL: ctrl_r <= {1'b0, reg_wdata_i[1:0]};
                peak_hold_pkg::OFS_SELF_LEVEL: self_level_r <= reg_wdata_i[VALUE_W-1:0];
                peak_hold_pkg::OFS_HIGH_THR: high_thr_r <= reg_wdata_i[VALUE_W-1:0];
                peak_hold_pkg::OFS_LOW_THR: low_thr_r <= reg_wdata_i[VALUE_W-1:0];
                peak_hold_pkg::OFS_IRQ_MASK: irq_mask_r <= reg_wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Sticky interrupt status, set wins over write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_stat_r <= 4'h0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            irq_stat_r <= (irq_stat_r & ~(irq_clr_wr ? reg_wdata_i[3:0] : 4'h0)) | irq_set;
            irq_r <= |(irq_stat_r & irq_mask_r);
            rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // Outputs from flip-flops
    assign reg_rdata_o = rdata_r;
    assign held_value_o = held_r;
    assign judge_high_o = judge_r.high;
    assign judge_go_o = judge_r.go;
    assign judge_low_o = judge_r.low;
    assign standby_o = standby_r;
    assign error_o = error_r;
    assign irq_o = irq_r;
endmodule : peak_hold_sampler
`default_nettype wire

// ---- bench/peak_hold_sampler_props.sv ----
// Port-level checker for the peak-hold sampler
`default_nettype none
module peak_hold_sampler_props #(
    parameter int VALUE_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic ext_reset_i,
    input wire logic set_button_i,
    input wire logic error_i,
    input wire logic [peak_hold_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [VALUE_W-1:0] held_value_o,
    input wire logic judge_high_o,
    input wire logic judge_go_o,
    input wire logic judge_low_o,
    input wire logic standby_o,
    input wire logic error_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Judgement outputs gathered
    wire [2:0] judge_w = {judge_high_o, judge_go_o, judge_low_o};
    // Steps of the error handling
    sequence s_quiet; (!ext_reset_i && !set_button_i)[*5]; endsequence
    sequence s_clear; (ext_reset_i && !error_i)[*3]; endsequence
    property p_one_hot; $onehot0(judge_w); endproperty
    property p_standby_dark; standby_o |-> judge_w == 3'h0; endproperty
    property p_reset_standby; $fell(reset_i) |-> standby_o && held_value_o == '0; endproperty
    property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
    property p_unmapped; reg_rd_i && reg_addr_i > 4'h8 |=> reg_rdata_o == 32'h0; endproperty
    property p_err_set; error_i |-> ##[1:4] error_o; endproperty
    property p_err_sticky; s_quiet ##0 error_o |=> error_o; endproperty
    property p_err_clear; s_clear |-> ##[0:4] !error_o; endproperty
    property p_clear_standby; $fell(error_o) |-> ##[0:2] standby_o; endproperty
    property p_standby_exit; $fell(standby_o) |-> ##[0:1] judge_w != 3'h0; endproperty
    a_one_hot: assert property (p_one_hot) else $error("Judgement not one-hot");
    a_standby_dark: assert property (p_standby_dark) else $error("Output on in standby");
    a_reset_standby: assert property (p_reset_standby) else $error("No standby");
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");
    a_err_set: assert property (p_err_set) else $error("Error not latched");
    a_err_sticky: assert property (p_err_sticky) else $error("Error dropped");
    a_err_clear: assert property (p_err_clear) else $error("Error not cleared");
    a_clear_standby: assert property (p_clear_standby) else $error("No standby");
    a_standby_exit: assert property (p_standby_exit) else $error("Exit without judge");
endmodule : peak_hold_sampler_props
bind peak_hold_sampler peak_hold_sampler_props #(.VALUE_W(VALUE_W)) props_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ext_reset_i(ext_reset_i),
    .set_button_i(set_button_i), .error_i(error_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .held_value_o(held_value_o),
    .judge_high_o(judge_high_o), .judge_go_o(judge_go_o), .judge_low_o(judge_low_o),
    .standby_o(standby_o), .error_o(error_o));
`default_nettype wire

// ---- bench/timing_controller.sv ----
// Model of the outside controller driving timing and reset pins
`default_nettype none
module timing_controller (
    input wire logic ref_clk_i,
    output logic timing_o,
    output logic ext_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both pins idle low
    initial begin
        timing_o = 1'b0;
        ext_reset_o = 1'b0;
    end
    // Timing level changes just after an edge and then holds
    task automatic set_timing(input logic level);
        @(posedge ref_clk_i);
        timing_o <= level;
    endtask : set_timing
    // Reset held for some cycles to clear a shown error
    task automatic pulse_reset(input int cycles);
        @(posedge ref_clk_i);
        ext_reset_o <= 1'b1;
        repeat (cycles) @(posedge ref_clk_i);
        ext_reset_o <= 1'b0;
    endtask : pulse_reset
endmodule : timing_controller
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the peak-hold sampler
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, reset_i, error_i, set_button_i, reg_wr_i, reg_rd_i, clk_en_i;
    logic [peak_hold_pkg::ADDR_W-1:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [15:0] live_value_i, held_value_o;
    logic judge_high_o, judge_go_o, judge_low_o, standby_o, error_o, irq_o;
    wire timing_w;
    wire ext_reset_w;
    wire [2:0] judges_w = {judge_high_o, judge_go_o, judge_low_o};
    int err_total = 0;
    int compares = 0;
    // Device and outside controller
    peak_hold_sampler dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .live_value_i(live_value_i), .timing_i(timing_w), .ext_reset_i(ext_reset_w),
        .set_button_i(set_button_i), .error_i(error_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .held_value_o(held_value_o), .judge_high_o(judge_high_o),
        .judge_go_o(judge_go_o), .judge_low_o(judge_low_o), .standby_o(standby_o),
        .error_o(error_o), .irq_o(irq_o));
    timing_controller ctrl_u (.ref_clk_i(ref_clk_i), .timing_o(timing_w),
        .ext_reset_o(ext_reset_w));
    // Clock of 40 ns
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, exp)
    endtask : rd_chk
    // Expected judgement from the reset thresholds
    function automatic logic [2:0] judge_of(input logic [15:0] v);
        if (v > peak_hold_pkg::HIGH_THR_RESET) return 3'b100;
        if (v < peak_hold_pkg::LOW_THR_RESET) return 3'b001;
        return 3'b010;
    endfunction : judge_of
    task automatic hold_chk(input logic [15:0] v);
        `CHK({held_value_o, judges_w}, {v, judge_of(v)})
    endtask : hold_chk
    task automatic live(input logic [15:0] v);
        @(posedge ref_clk_i);
        live_value_i <= v;
        tick(6);
    endtask : live
    task automatic tmg(input logic l);
        ctrl_u.set_timing(l);
        tick(6);
    endtask : tmg
    task automatic t_reset();
        `CHK({standby_o, held_value_o, judges_w}, {1'b1, 16'h0, 3'b000})
        rd_chk(peak_hold_pkg::OFS_SELF_LEVEL, 32'h0100);
        rd_chk(peak_hold_pkg::OFS_HIGH_THR, 32'hc000);
        rd_chk(peak_hold_pkg::OFS_LOW_THR, 32'h4000);
        rd_chk(peak_hold_pkg::OFS_IRQ_MASK, 32'h0);
        rd_chk(4'hf, 32'h0);
    endtask : t_reset
    task automatic t_ext_end();
        wr(peak_hold_pkg::OFS_IRQ_MASK, 32'h1);
        live(16'h5000);
        live(16'hc000);
        live(16'h3000);
        `CHK(held_value_o, 16'h0)
        tmg(1'b1);
        hold_chk(16'hc000);
        rd_chk(peak_hold_pkg::OFS_HELD, 32'h0000_c000);
        `CHK({standby_o, irq_o}, 2'b01)
        wr(peak_hold_pkg::OFS_IRQ_STAT, 32'hf);
        wr(peak_hold_pkg::OFS_IRQ_MASK, 32'h0);
        tick(2);
        `CHK(irq_o, 1'b0)
        tmg(1'b0);
        live(16'hc001);
        live(16'h1000);
        tmg(1'b1);
        hold_chk(16'hc001);
        `CHK(irq_o, 1'b0)
    endtask : t_ext_end
    task automatic t_ext_cont();
        wr(peak_hold_pkg::OFS_CTRL, 32'h6);
        live(16'h3fff);
        tmg(1'b0);
        hold_chk(16'h3fff);
        live(16'h4000);
        hold_chk(16'h4000);
        tmg(1'b1);
        live(16'hf000);
        hold_chk(16'h4000);
        live(16'h2000);
        tmg(1'b0);
        hold_chk(16'h2000);
    endtask : t_ext_cont
    task automatic t_self();
        wr(peak_hold_pkg::OFS_CTRL, 32'h5);
        rd_chk(peak_hold_pkg::OFS_CTRL, 32'h1);
        live(16'h0010);
        live(16'h6000);
        `CHK(judges_w, 3'b000)
        live(16'h7000);
        live(16'h0020);
        hold_chk(16'h7000);
        live(16'h0030);
        hold_chk(16'h7000);
        live(16'hd000);
        `CHK({held_value_o, judges_w}, {16'h7000, 3'b000})
        live(16'h0040);
        hold_chk(16'hd000);
        wr(peak_hold_pkg::OFS_CTRL, 32'h7);
        live(16'h3000);
        hold_chk(16'h3000);
        live(16'hc001);
        hold_chk(16'hc001);
        clk_en_i <= 1'b0;
        live(16'hffff);
        hold_chk(16'hc001);
        clk_en_i <= 1'b1;
        live(16'hffff);
        hold_chk(16'hffff);
    endtask : t_self
    task automatic t_error();
        wr(peak_hold_pkg::OFS_CTRL, 32'h0);
        @(posedge ref_clk_i);
        error_i <= 1'b1;
        tick(4);
        error_i <= 1'b0;
        `CHK(error_o, 1'b1)
        ctrl_u.pulse_reset(4);
        tick(6);
        `CHK({error_o, standby_o, held_value_o, judges_w}, {2'b01, 16'h0, 3'b000})
        rd_chk(peak_hold_pkg::OFS_STATUS, 32'h0);
        error_i <= 1'b1;
        tick(4);
        error_i <= 1'b0;
        tick(2);
        set_button_i <= 1'b1;
        tick(4);
        set_button_i <= 1'b0;
        tick(6);
        `CHK({error_o, standby_o}, 2'b01)
    endtask : t_error
    task automatic end_of_test();
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        {reset_i, error_i, set_button_i, reg_wr_i, reg_rd_i} = 5'h10;
        reg_addr_i = 4'h0;
        clk_en_i = 1'b1;
        reg_wdata_i = 32'h0;
        live_value_i = 16'h0;
        tick(10);
        reset_i <= 1'b0;
        tick(1);
        t_reset();
        t_ext_end();
        t_ext_cont();
        t_self();
        t_error();
        end_of_test();
    end
    // Watchdog
    initial begin
        tick(5000);
        err_total++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
